// ===== rtl/flash_seq_pkg.sv
/*
  Shared constants of the flash self-programming sequencer: register map,
  control fields, key values, flash geometry, state and operation codes.
  Assumes a 32-bit APB with byte addresses in the low eight bits.
*/
package flash_seq_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_KEY    = 8'h04;
  localparam logic [7:0] ADDR_PTR    = 8'h08;
  localparam logic [7:0] ADDR_TBL_LO = 8'h0C;
  localparam logic [7:0] ADDR_TBL_HI = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // flash_control_reg fields and status index field
  localparam int unsigned CTRL_START_BIT = 15;
  localparam int unsigned CTRL_FLASH_MODIFY_ENABLE_BIT  = 14;
  localparam int unsigned CTRL_ERASE_BIT = 6;
  localparam int unsigned STAT_IDX_LSB   = 8;

  // flash_op_select codes
  localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
  localparam logic [3:0] OP_ROW_PROG   = 4'h1;
  localparam logic [3:0] OP_WORD_PROG  = 4'h3;

  // unlock key sequence
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // geometry, addresses count instructions
  localparam int unsigned ADDR_W      = 17;
  localparam int unsigned INSTR_W     = 24;
  localparam int unsigned ROW_WORDS   = 64;
  localparam int unsigned ROW_BITS    = 6;
  localparam int unsigned PAGE_ROWS   = 8;
  localparam int unsigned PAGE_BITS   = 9;
  localparam int unsigned INSTR_BYTES = 3;
  localparam int unsigned ROW_BYTES   = ROW_WORDS * INSTR_BYTES;
  localparam int unsigned PAGE_BYTES  = ROW_BYTES * PAGE_ROWS;

  // reset values
  localparam logic [3:0]  OP_RST    = 4'h0;
  localparam logic [15:0] TIMER_RST = 16'h0000;

  // operation durations in clock cycles
  localparam int unsigned ROW_CYCLES_DEF   = 11064;
  localparam int unsigned ERASE_CYCLES_DEF = 11064;
  localparam int unsigned WORD_CYCLES_DEF  = 1024;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ERASE  = 3'b001,
    ST_STREAM = 3'b010,
    ST_WORD   = 3'b011,
    ST_WAIT   = 3'b100
  } state_t;

  typedef enum logic [1:0] {
    OPK_NONE  = 2'b00,
    OPK_ERASE = 2'b01,
    OPK_ROW   = 2'b10,
    OPK_WORD  = 2'b11
  } op_kind_t;

endpackage : flash_seq_pkg

// ===== rtl/flash_self_program_sequencer.sv
/*
  Run-time self-programming sequencer: holding buffers, unlock key,
  flash control register, page erase and row or word programming.
  Assumes an APB master on the same clock and a flash array that takes
  one-cycle erase and write strobes with address and data.
*/
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module flash_self_program_sequencer
  import flash_seq_pkg::*;
#(
  parameter int unsigned ROW_CYCLES   = ROW_CYCLES_DEF,
  parameter int unsigned ERASE_CYCLES = ERASE_CYCLES_DEF,
  parameter int unsigned WORD_CYCLES  = WORD_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata_q,
  output logic                     pready_q,
  output logic                     pslverr_q,
  // flash array
  output logic                     flash_erase_q,
  output logic                     flash_write_q,
  output logic      [ADDR_W-1:0]   flash_addr_q,
  output logic      [INSTR_W-1:0]  flash_wdata_q,
  // processor
  output logic                     cpu_stall_q
);

  function automatic op_kind_t decode_op(input logic [3:0] op,
                                         input logic erase, input logic flash_modify_enable);
    op_kind_t k;
    k = OPK_NONE;
    if (flash_modify_enable && erase && op == OP_PAGE_ERASE) k = OPK_ERASE;
    if (flash_modify_enable && !erase && op == OP_ROW_PROG)  k = OPK_ROW;
    if (flash_modify_enable && !erase && op == OP_WORD_PROG) k = OPK_WORD;
    return k;
  endfunction : decode_op

  function automatic logic is_table(input logic [7:0] a);
    return (a == ADDR_TBL_LO) || (a == ADDR_TBL_HI);
  endfunction : is_table

  //////////////////////////////////////////////////////////////////////////////
  // state

  state_t               state_q, state_d;
  logic [15:0]          timer_q, timer_d;
  logic [ROW_BITS-1:0]  cnt_q, cnt_d;
  logic [ROW_BITS-1:0]  idx_q, idx_d;
  logic [ADDR_W-1:0]    ptr_q, ptr_d;
  logic                 start_q, start_d;
  logic                 flash_modify_enable_q, flash_modify_enable_d;
  logic                 erase_q, erase_d;
  logic [3:0]           op_q, op_d;
  logic                 armed_q, armed_d;
  logic                 unlocked_q, unlocked_d;
  logic                 wait_q, wait_d;
  logic [31:0]          prdata_d;
  logic                 pready_d, pslverr_d;
  logic                 flash_erase_d, flash_write_d;
  logic [ADDR_W-1:0]    flash_addr_d;
  logic [INSTR_W-1:0]   flash_wdata_d;
  logic                 cpu_stall_d;

  logic [15:0]          buf_lo [ROW_WORDS];
  logic [7:0]           buf_hi [ROW_WORDS];

  logic                 busy, acc, done_acc, wr, mapped, go;
  op_kind_t             kind;
  logic [31:0]          rdata;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode

  always_comb begin
    busy     = state_q != ST_IDLE;
    acc      = psel && penable;
    done_acc = acc && pready_q;
    wr       = done_acc && pwrite;
    mapped   = paddr == ADDR_CTRL || paddr == ADDR_KEY || paddr == ADDR_PTR ||
               is_table(paddr) || paddr == ADDR_STATUS;
    kind     = decode_op(pwdata[3:0], pwdata[CTRL_ERASE_BIT], pwdata[CTRL_FLASH_MODIFY_ENABLE_BIT]);
    // start only after the full key sequence and a valid operation
    go       = wr && paddr == ADDR_CTRL && pwdata[CTRL_START_BIT] &&
               unlocked_q && kind != OPK_NONE;
    rdata    = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL: begin
        rdata[CTRL_START_BIT] = start_q;
        rdata[CTRL_FLASH_MODIFY_ENABLE_BIT]  = flash_modify_enable_q;
        rdata[CTRL_ERASE_BIT] = erase_q;
        rdata[3:0]            = op_q;
      end
      ADDR_PTR: begin
        rdata[ADDR_W-1:0] = ptr_q;
      end
      ADDR_STATUS: begin
        rdata[0] = busy;
        rdata[1] = unlocked_q;
        rdata[STAT_IDX_LSB +: ROW_BITS] = idx_q;
      end
      default: begin
        rdata = 32'h0000_0000;
      end
    endcase
    // table accesses wait one extra cycle; nothing answers while busy
    wait_d    = acc && is_table(paddr) && !pready_q && !busy;
    pready_d  = acc && !pready_q && !busy &&
                (!is_table(paddr) || wait_q);
    prdata_d  = (pready_d && !pwrite) ? rdata : 32'h0000_0000;
    pslverr_d = pready_d && !mapped;
  end

  //////////////////////////////////////////////////////////////////////////////
  // key, control, pointer and buffer index

  always_comb begin
    armed_d    = armed_q;
    unlocked_d = unlocked_q;
    start_d    = start_q;
    flash_modify_enable_d     = flash_modify_enable_q;
    erase_d    = erase_q;
    op_d       = op_q;
    ptr_d      = ptr_q;
    idx_d      = idx_q;
    if (wr) begin
      // any write in between breaks the key sequence
      armed_d    = paddr == ADDR_KEY && pwdata[7:0] == KEY_FIRST;
      unlocked_d = paddr == ADDR_KEY && pwdata[7:0] == KEY_SECOND && armed_q;
      unique case (paddr)
        ADDR_CTRL: begin
          flash_modify_enable_d  = pwdata[CTRL_FLASH_MODIFY_ENABLE_BIT];
          erase_d = pwdata[CTRL_ERASE_BIT];
          op_d    = pwdata[3:0];
          start_d = go;
        end
        ADDR_PTR: begin
          ptr_d = pwdata[ADDR_W-1:0];
          idx_d = pwdata[ROW_BITS-1:0];
        end
        ADDR_TBL_HI: begin
          idx_d = idx_q + 6'h01;
        end
        default: begin
          idx_d = idx_q;
        end
      endcase
    end
    if (state_q == ST_WAIT && timer_q == TIMER_RST) begin
      start_d = 1'b0;
      idx_d   = '0;
    end
  end

  // holding buffers, no reset needed
  always_ff @(posedge clock) begin
    if (wr && paddr == ADDR_TBL_LO) begin
      buf_lo[idx_q] <= pwdata[15:0];
    end
    if (wr && paddr == ADDR_TBL_HI) begin
      buf_hi[idx_q] <= pwdata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // operation sequencer

  always_comb begin
    state_d       = state_q;
    timer_d       = (busy && timer_q != TIMER_RST) ? timer_q - 16'h0001 : timer_q;
    cnt_d         = cnt_q;
    flash_erase_d = 1'b0;
    flash_write_d = 1'b0;
    flash_addr_d  = flash_addr_q;
    flash_wdata_d = flash_wdata_q;
    unique case (state_q)
      ST_IDLE: begin
        cnt_d = '0;
        if (go) begin
          unique case (kind)
            OPK_ERASE: begin
              state_d = ST_ERASE;
              timer_d = 16'(ERASE_CYCLES - 1);
            end
            OPK_ROW: begin
              state_d = ST_STREAM;
              timer_d = 16'(ROW_CYCLES - 1);
            end
            OPK_WORD: begin
              state_d = ST_WORD;
              timer_d = 16'(WORD_CYCLES - 1);
            end
            OPK_NONE: begin
              state_d = ST_IDLE;
            end
          endcase
        end
      end
      ST_ERASE: begin
        flash_erase_d = 1'b1;
        flash_addr_d  = {ptr_q[ADDR_W-1:PAGE_BITS], {PAGE_BITS{1'b0}}};
        state_d       = ST_WAIT;
      end
      ST_STREAM: begin
        flash_write_d = 1'b1;
        flash_addr_d  = {ptr_q[ADDR_W-1:ROW_BITS], cnt_q};
        flash_wdata_d = {buf_hi[cnt_q], buf_lo[cnt_q]};
        cnt_d         = cnt_q + 6'h01;
        if (cnt_q == 6'(ROW_WORDS - 1)) begin
          state_d = ST_WAIT;
        end
      end
      ST_WORD: begin
        flash_write_d = 1'b1;
        flash_addr_d  = ptr_q;
        flash_wdata_d = {buf_hi[ptr_q[ROW_BITS-1:0]], buf_lo[ptr_q[ROW_BITS-1:0]]};
        state_d       = ST_WAIT;
      end
      ST_WAIT: begin
        if (timer_q == TIMER_RST) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    cpu_stall_d = state_d != ST_IDLE;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q       <= ST_IDLE;
      timer_q       <= TIMER_RST;
      cnt_q         <= '0;
      idx_q         <= '0;
      ptr_q         <= '0;
      start_q       <= 1'b0;
      flash_modify_enable_q        <= 1'b0;
      erase_q       <= 1'b0;
      op_q          <= OP_RST;
      armed_q       <= 1'b0;
      unlocked_q    <= 1'b0;
      wait_q        <= 1'b0;
      prdata_q      <= 32'h0000_0000;
      pready_q      <= 1'b0;
      pslverr_q     <= 1'b0;
      flash_erase_q <= 1'b0;
      flash_write_q <= 1'b0;
      flash_addr_q  <= '0;
      flash_wdata_q <= '0;
      cpu_stall_q   <= 1'b0;
    end else begin
      state_q       <= state_d;
      timer_q       <= timer_d;
      cnt_q         <= cnt_d;
      idx_q         <= idx_d;
      ptr_q         <= ptr_d;
      start_q       <= start_d;
      flash_modify_enable_q        <= flash_modify_enable_d;
      erase_q       <= erase_d;
      op_q          <= op_d;
      armed_q       <= armed_d;
      unlocked_q    <= unlocked_d;
      wait_q        <= wait_d;
      prdata_q      <= prdata_d;
      pready_q      <= pready_d;
      pslverr_q     <= pslverr_d;
      flash_erase_q <= flash_erase_d;
      flash_write_q <= flash_write_d;
      flash_addr_q  <= flash_addr_d;
      flash_wdata_q <= flash_wdata_d;
      cpu_stall_q   <= cpu_stall_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // an operation only begins on the control write that follows the key
  property p_start_needs_key;
    $rose(cpu_stall_q) |-> $past(unlocked_q) && $past(wr) && $past(paddr) == ADDR_CTRL;
  endproperty
  a_start_needs_key: assert property (p_start_needs_key)
    else $error("start accepted without unlock key");

  property p_locked_start_refused;
    (wr && paddr == ADDR_CTRL && pwdata[CTRL_START_BIT] && !unlocked_q)
      |=> !start_q && !cpu_stall_q;
  endproperty
  a_locked_start_refused: assert property (p_locked_start_refused)
    else $error("locked start was not refused");

  property p_erase_decode;
    (go && kind == OPK_ERASE) |=> ##1 flash_erase_q && !flash_write_q;
  endproperty
  a_erase_decode: assert property (p_erase_decode)
    else $error("erase code did not erase");

  property p_erase_page_aligned;
    flash_erase_q |-> flash_addr_q[PAGE_BITS-1:0] == '0;
  endproperty
  a_erase_page_aligned: assert property (p_erase_page_aligned)
    else $error("erase address not page aligned");

  property p_row_burst;
    (go && kind == OPK_ROW) |=> ##1 (flash_write_q && flash_addr_q[ROW_BITS-1:0] == '0)
      ##1 flash_write_q[*8];
  endproperty
  a_row_burst: assert property (p_row_burst)
    else $error("row burst did not start at row base");

  property p_table_two_cycles;
    (done_acc && is_table(paddr)) |-> $past(acc, 2) && !$past(pready_q, 1);
  endproperty
  a_table_two_cycles: assert property (p_table_two_cycles)
    else $error("table write finished too early");

  property p_sequential_fill;
    (wr && paddr == ADDR_TBL_HI) |=> idx_q == $past(idx_q) + 6'h01;
  endproperty
  a_sequential_fill: assert property (p_sequential_fill)
    else $error("buffer index did not advance");

  property p_stall_blocks_bus;
    cpu_stall_q |-> !pready_d;
  endproperty
  a_stall_blocks_bus: assert property (p_stall_blocks_bus)
    else $error("bus answered during operation");

  property p_start_self_clears;
    $fell(cpu_stall_q) |-> !start_q && $past(start_q);
  endproperty
  a_start_self_clears: assert property (p_start_self_clears)
    else $error("start bit not cleared at end");

  c_page_erase: cover property (go && kind == OPK_ERASE);
  c_row_prog:   cover property (go && kind == OPK_ROW);
  c_word_prog:  cover property (go && kind == OPK_WORD);
  c_op_done:    cover property ($fell(cpu_stall_q));

endmodule : flash_self_program_sequencer

`default_nettype wire

// ===== dv/flash_array_model.sv
/*
  Behavioural program flash array: 24-bit words, page erase fills ones.
  Assumes one-cycle erase and write strobes from the sequencer on clock.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
  import flash_seq_pkg::*;
(
  // clock
  input wire logic               clock,
  // strobes and data
  input wire logic               erase,
  input wire logic               write,
  input wire logic [ADDR_W-1:0]  addr,
  input wire logic [INSTR_W-1:0] wdata
);
  logic [INSTR_W-1:0] mem [0:(1<<ADDR_W)-1];
  int                 n_wr;
  int                 n_er;
  logic [ADDR_W-1:0]  last_er;

  initial begin
    n_wr = 0;
    n_er = 0;
    last_er = '0;
  end

  always @(posedge clock) begin
    if (erase === 1'b1) begin
      n_er <= n_er + 1;
      last_er <= addr;
      for (int i = 0; i < PAGE_ROWS * ROW_WORDS; i++) begin
        mem[{addr[ADDR_W-1:PAGE_BITS], PAGE_BITS'(0)} + i] <= '1;
      end
    end
    if (write === 1'b1) begin
      n_wr <= n_wr + 1;
      mem[addr] <= wdata;
    end
  end
endmodule : flash_array_model
`default_nettype wire

// ===== dv/flash_self_program_sequencer_tb_top.sv
/*
  Self-checking bench: APB master tasks, refusals, row, word, page erase.
  Assumes the sequencer and the flash array model on one 20 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_sequencer_tb_top;
  import flash_seq_pkg::*;
  localparam int unsigned N_ROW = 100;
  localparam int unsigned N_ER  = 80;
  localparam int unsigned N_WD  = 70;
  localparam int          LIMIT = 20000;
  logic               clock;
  logic               rst;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic               flash_erase_q;
  logic               flash_write_q;
  logic [ADDR_W-1:0]  flash_addr_q;
  logic [INSTR_W-1:0] flash_wdata_q;
  logic               cpu_stall_q;
  int                 n_errors;
  int                 checks_done;
  int                 cyc;
  int                 cnt0;
  integer             seed;
  logic [31:0]        rd;
  logic               err;
  logic [INSTR_W-1:0] row_data [0:ROW_WORDS-1];
  logic [INSTR_W-1:0] wd;
  logic [ADDR_W-1:0]  base;
  logic [ADDR_W-1:0]  wa;

  flash_self_program_sequencer #(
    .ROW_CYCLES  (N_ROW),
    .ERASE_CYCLES(N_ER),
    .WORD_CYCLES (N_WD)
  ) u_flash_self_program_sequencer (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .flash_erase_q(flash_erase_q),
    .flash_write_q(flash_write_q), .flash_addr_q(flash_addr_q),
    .flash_wdata_q(flash_wdata_q), .cpu_stall_q(cpu_stall_q)
  );

  flash_array_model u_flash_array_model (
    .clock(clock), .erase(flash_erase_q), .write(flash_write_q),
    .addr(flash_addr_q), .wdata(flash_wdata_q)
  );

  always #25 clock = ~clock;

  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ctrl_w(input logic [3:0] op, input logic er);
    logic [31:0] v;
    v = 32'h0;
    v[CTRL_START_BIT] = 1'b1;
    v[CTRL_FLASH_MODIFY_ENABLE_BIT] = 1'b1;
    v[CTRL_ERASE_BIT] = er;
    v[3:0] = op;
    return v;
  endfunction : ctrl_w

  function automatic logic [31:0] page_base(input logic [ADDR_W-1:0] a);
    return 32'({a[ADDR_W-1:PAGE_BITS], PAGE_BITS'(0)});
  endfunction : page_base

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // pready sampled at the rising edge; data taken and request released there
    do @(posedge clock); while (pready_q !== 1'b1);
    rd = prdata_q;
    err = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // unlock, start, measure stall from the completing edge
  task automatic run_op(input logic [31:0] c, input int n);
    int   k;
    logic seen;
    k = 0;
    seen = 1'b0;
    apb(1'b1, ADDR_KEY, 32'(KEY_FIRST));
    apb(1'b1, ADDR_KEY, 32'(KEY_SECOND));
    apb(1'b1, ADDR_CTRL, c);
    do begin
      @(negedge clock);
      k++;
      if (cpu_stall_q === 1'b1) seen = 1'b1;
    end while ((cpu_stall_q === 1'b1 || !seen) && k < 2000);
    chk("stall seen", {31'h0, seen}, 32'h1);
    chk("stall length", 32'(k), 32'(n + 1));
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("start cleared", {31'h0, rd[CTRL_START_BIT]}, 32'h0);
  endtask : run_op

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {n_errors, checks_done, cyc} = '0;
    seed = 32'hB9172572;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status reset", rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    done("reset and map");
    // no key, broken key, invalid op combination
    for (int t = 0; t < 3; t++) begin
      if (t > 0) apb(1'b1, ADDR_KEY, 32'(KEY_FIRST));
      if (t == 1) apb(1'b1, ADDR_PTR, 32'h0);
      if (t > 0) apb(1'b1, ADDR_KEY, 32'(KEY_SECOND));
      if (t > 0) apb(1'b0, ADDR_STATUS, 32'h0);
      if (t > 0) chk("unlock status", rd, (t == 2) ? 32'h2 : 32'h0);
      apb(1'b1, ADDR_CTRL, ctrl_w(t == 2 ? OP_PAGE_ERASE : OP_ROW_PROG, 1'b0));
      repeat (3) @(negedge clock);
      chk("refused stall", {31'h0, cpu_stall_q}, 32'h0);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("refused start", {31'h0, rd[CTRL_START_BIT]}, 32'h0);
    end
    chk("refused strobes", 32'(u_flash_array_model.n_wr + u_flash_array_model.n_er), 32'h0);
    done("refusals");
    base = ADDR_W'($random(seed)) & 17'h1FFC0;
    apb(1'b1, ADDR_PTR, 32'(base));
    for (int i = 0; i < ROW_WORDS; i++) begin
      row_data[i] = INSTR_W'($random(seed));
      apb(1'b1, ADDR_TBL_LO, {16'h0, row_data[i][15:0]});
      apb(1'b1, ADDR_TBL_HI, {24'h0, row_data[i][23:16]});
    end
    cnt0 = u_flash_array_model.n_wr;
    run_op(ctrl_w(OP_ROW_PROG, 1'b0), N_ROW);
    chk("row pulses", 32'(u_flash_array_model.n_wr - cnt0), 32'(ROW_WORDS));
    for (int i = 0; i < ROW_WORDS; i++) begin
      chk("row word", 32'(u_flash_array_model.mem[base + i]), 32'(row_data[i]));
    end
    done("row program");
    wa = (base ^ 17'h00200) | ADDR_W'($random(seed) & 63);
    wd = INSTR_W'($random(seed));
    apb(1'b1, ADDR_PTR, 32'(wa));
    apb(1'b1, ADDR_TBL_LO, {16'h0, wd[15:0]});
    apb(1'b1, ADDR_TBL_HI, {24'h0, wd[23:16]});
    cnt0 = u_flash_array_model.n_wr;
    run_op(ctrl_w(OP_WORD_PROG, 1'b0), N_WD);
    chk("word pulses", 32'(u_flash_array_model.n_wr - cnt0), 32'h1);
    chk("word value", 32'(u_flash_array_model.mem[wa]), 32'(wd));
    done("word program");
    apb(1'b1, ADDR_PTR, 32'(base + 5));
    cnt0 = u_flash_array_model.n_er;
    run_op(ctrl_w(OP_PAGE_ERASE, 1'b1), N_ER);
    chk("erase pulses", 32'(u_flash_array_model.n_er - cnt0), 32'h1);
    chk("erase address", 32'(u_flash_array_model.last_er), page_base(base));
    chk("erased first", 32'(u_flash_array_model.mem[base]), 32'hFFFFFF);
    chk("erased last", 32'(u_flash_array_model.mem[base + 63]), 32'hFFFFFF);
    chk("other page kept", 32'(u_flash_array_model.mem[wa]), 32'(wd));
    done("page erase");
    results();
  end
endmodule : flash_self_program_sequencer_tb_top
`default_nettype wire
